// ==== design/ist_pkg.sv ====
// constants, field layout and types shared by the i2c slave status tracker
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses
package ist_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          STAT_W        = 16;
  localparam int          N_ID          = 4;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_ID0       = 8'h08;
  localparam logic [7:0]  OFS_ID1       = 8'h0C;
  localparam logic [7:0]  OFS_ID2       = 8'h10;
  localparam logic [7:0]  OFS_ID3       = 8'h14;
  localparam logic [7:0]  OFS_ALT       = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h20;
  // control fields
  localparam int          CTRL_SLV_EN   = 0;
  localparam int          CTRL_GC_EN    = 2;
  localparam int          CTRL_HGC_EN   = 3;
  localparam int          CTRL_GCS_CLR  = 4;
  localparam int          CTRL_STOP_IE  = 8;
  localparam logic [15:0] CTRL_RW_MASK  = 16'h010D;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [7:0]  ID_RST        = 8'h00;
  // status fields
  localparam int          ST_START      = 14;
  localparam int          ST_REPEATED_START_FLAG   = 13;
  localparam int          ST_MATCHED_ID_INDEX_LO   = 11;
  localparam int          ST_STOP       = 10;
  localparam int          ST_GCKIND_LO  = 8;
  localparam int          ST_GCINT      = 7;
  localparam int          ST_BUSY       = 6;
  // interrupt status / mask layout
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_STOP      = 0;
  localparam int          IRQ_REPEATED_START_FLAG  = 1;
  localparam int          IRQ_GC        = 2;
  localparam logic [2:0]  IRQ_RST       = 3'h0;
  // bus codes
  localparam logic [7:0]  GC_ADDR       = 8'h00;
  localparam logic [7:0]  START_BYTE    = 8'h01;
  localparam logic [4:0]  HS_PREFIX     = 5'h01;
  localparam logic [7:0]  GC_RESET_PROG = 8'h06;
  localparam logic [7:0]  GC_PROG       = 8'h04;
  // bit counter marks in the bus monitor and axi response codes
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  BIT_DONE      = 4'h9;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    GCK_NONE       = 2'b00,
    GCK_RESET_PROG = 2'b01,
    GCK_PROG       = 2'b10,
    GCK_HW         = 2'b11
  } ist_gc_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_GC   = 3'b010,
    ST_DATA = 3'b011,
    ST_SKIP = 3'b100
  } ist_state_type;
endpackage

// ==== design/ist_bus_mon.sv ====
// i2c bus monitor: synchronises scl/sda, finds start, stop and received bytes,
// and pulls sda low in the acknowledge slot when asked to.
// assumes scl high and low phases each last several aclk cycles.
`timescale 1ns/10ps
module ist_bus_mon
  import ist_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       hold,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_req,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            start_det,
  output logic            stop_det,
  output logic            byte_valid,
  output logic [7:0]      rx_byte
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [3:0] cnt_r;
  logic       active_r;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  assign scl_s    = scl_sync_r[1];
  assign sda_s    = sda_sync_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c  = scl_s & scl_d_r & ~sda_s & sda_d_r;
  assign stop_c   = scl_s & scl_d_r & sda_s & ~sda_d_r;
  // open drain: only ever drive low
  assign sda_o    = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      start_det  <= 1'b0;
      stop_det   <= 1'b0;
      byte_valid <= 1'b0;
      rx_byte    <= 8'h00;
      cnt_r      <= 4'h0;
      active_r   <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      start_det  <= start_c;
      stop_det   <= stop_c;
      byte_valid <= 1'b0;
      if (start_c || stop_c) begin
        cnt_r    <= 4'h0;
        sda_oe   <= 1'b0;
        active_r <= start_c;
      end else if (active_r) begin
        if (scl_rise && cnt_r < BIT_ACK) begin
          rx_byte <= {rx_byte[6:0], sda_s};
          cnt_r   <= 4'(cnt_r + 4'h1);
          if (cnt_r == 4'(BIT_ACK - 4'h1)) begin
            byte_valid <= 1'b1;
          end
        end else if (scl_rise && cnt_r == BIT_ACK) begin
          cnt_r <= BIT_DONE;
        end else if (scl_fall && cnt_r == BIT_ACK) begin
          // ack_req has settled long before this edge
          sda_oe <= ack_req;
        end else if (scl_fall && cnt_r == BIT_DONE) begin
          sda_oe <= 1'b0;
          cnt_r  <= 4'h0;
        end
      end
    end
  end
endmodule

// ==== design/ist_top.sv ====
// i2c slave status tracker: address decode, bus event flags, general call
// type, interrupt gating and an axi4-lite register slave.
// assumes scl/sda arrive asynchronously; sda is open drain resolved outside.
`timescale 1ns/10ps
module ist_top
  import ist_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ist_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [ist_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [ist_pkg::ADDR_W-1:0] araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [ist_pkg::DATA_W-1:0] rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  output logic                      irq
);
  import ist_pkg::*;

  logic [15:0]     ctrl_r;
  logic [7:0]      id_r [N_ID];
  logic [7:0]      alt_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic            aw_have_r;
  logic            w_have_r;
  logic [7:0]      wr_addr_r;
  logic [31:0]     wr_data_r;
  logic [3:0]      wr_strb_r;
  ist_state_type   state_r;
  logic            ack_req_r;
  logic            start_flag_r;
  logic            rep_flag_r;
  logic            rep_pend_r;
  logic [1:0]      matched_id_index_r;
  logic            stop_flag_r;
  ist_gc_kind_type gc_kind_r;
  logic            gc_int_r;
  logic            busy_r;
  logic            matched_r;
  logic            start_det;
  logic            stop_det;
  logic            byte_valid;
  logic [7:0]      rx_byte;
  logic            slv_en;
  logic            gc_en;
  logic            aw_ok;
  logic            w_ok;
  logic            wr_fire;
  logic            ar_ok;
  logic            rd_status;
  logic            gcs_clr;
  logic            id_hit;
  logic [1:0]      id_idx;
  logic            gc_hit;
  logic            addr_ev;
  logic            start_set;
  logic            rep_set;
  logic            stop_set;
  logic            kind_ev;
  ist_gc_kind_type kind_new;
  logic [IRQ_W-1:0] irq_ev;
  logic [15:0]     status_w;
  logic [31:0]     rd_data;

  // address 0 belongs to the general call and the start byte, so an id register
  // left at its reset value must not turn them into an id match
  function automatic logic id_match(input logic [7:0] b, input logic [7:0] id);
    return (b[7:1] == id[6:0]) && (b[7:1] != GC_ADDR[7:1]);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ID0) || (a == OFS_ID1) ||
           (a == OFS_ID2) || (a == OFS_ID3) || (a == OFS_ALT) ||
           (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  assign slv_en    = ctrl_r[CTRL_SLV_EN];
  assign gc_en     = ctrl_r[CTRL_GC_EN];
  assign aw_ok     = awvalid & awready;
  assign w_ok      = wvalid & wready;
  assign wr_fire   = aw_have_r & w_have_r & ~bvalid;
  assign ar_ok     = arvalid & arready;
  assign rd_status = ar_ok && (araddr == OFS_STATUS);
  assign gcs_clr   = wr_fire && (wr_addr_r == OFS_CTRL) && wr_strb_r[0] &&
                     wr_data_r[CTRL_GCS_CLR];

  // write channels are taken independently and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 32'h0000_0000;
      wr_strb_r <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (aw_ok) begin
        awready   <= 1'b0;
        aw_have_r <= 1'b1;
        wr_addr_r <= awaddr;
      end
      if (w_ok) begin
        wready    <= 1'b0;
        w_have_r  <= 1'b1;
        wr_data_r <= wdata;
        wr_strb_r <= wstrb;
      end
      if (wr_fire) begin
        bvalid    <= 1'b1;
        bresp     <= addr_ok(wr_addr_r) ? RESP_OKAY : RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= CTRL_RST;
      alt_r      <= ID_RST;
      irq_mask_r <= IRQ_RST;
      for (int i = 0; i < N_ID; i++) begin
        id_r[i] <= ID_RST;
      end
    end else if (wr_fire) begin
      if (wr_addr_r == OFS_CTRL) begin
        ctrl_r <= 16'(apply_strb({16'h0000, ctrl_r}, wr_data_r, wr_strb_r)) & CTRL_RW_MASK;
      end
      if (wr_addr_r == OFS_ALT) begin
        alt_r <= 8'(apply_strb({24'h00_0000, alt_r}, wr_data_r, wr_strb_r));
      end
      if (wr_addr_r == OFS_IRQ_MASK) begin
        irq_mask_r <= 3'(apply_strb({29'h0, irq_mask_r}, wr_data_r, wr_strb_r));
      end
      for (int i = 0; i < N_ID; i++) begin
        if (wr_addr_r == 8'(OFS_ID0 + 8'(i * 4))) begin
          id_r[i] <= 8'(apply_strb({24'h00_0000, id_r[i]}, wr_data_r, wr_strb_r));
        end
      end
    end
  end

  assign status_w = {1'b0, start_flag_r, rep_flag_r, matched_id_index_r, stop_flag_r, gc_kind_r,
                     gc_int_r, busy_r, 6'h00};

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (araddr)
      OFS_CTRL:     rd_data = {16'h0000, ctrl_r};
      OFS_STATUS:   rd_data = {16'h0000, status_w};
      OFS_ID0:      rd_data = {24'h00_0000, id_r[0]};
      OFS_ID1:      rd_data = {24'h00_0000, id_r[1]};
      OFS_ID2:      rd_data = {24'h00_0000, id_r[2]};
      OFS_ID3:      rd_data = {24'h00_0000, id_r[3]};
      OFS_ALT:      rd_data = {24'h00_0000, alt_r};
      OFS_IRQ_STAT: rd_data = {29'h0, irq_stat_r};
      OFS_IRQ_MASK: rd_data = {29'h0, irq_mask_r};
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ar_ok) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  ist_bus_mon u_mon (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .hold       (~slv_en),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .ack_req    (ack_req_r),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .start_det  (start_det),
    .stop_det   (stop_det),
    .byte_valid (byte_valid),
    .rx_byte    (rx_byte)
  );

  // lowest id index wins if two id registers hold the same address
  always_comb begin
    id_hit = 1'b0;
    id_idx = 2'h0;
    for (int i = N_ID - 1; i >= 0; i--) begin
      if (id_match(rx_byte, id_r[i])) begin
        id_hit = 1'b1;
        id_idx = 2'(i);
      end
    end
  end

  assign gc_hit    = (rx_byte == GC_ADDR) && gc_en;
  assign addr_ev   = byte_valid && (state_r == ST_ADDR);
  assign start_set = addr_ev && (id_hit || gc_hit || (rx_byte[7:3] == HS_PREFIX) ||
                                 (rx_byte == START_BYTE));
  assign rep_set   = addr_ev && (id_hit || gc_hit) && rep_pend_r;
  assign stop_set  = stop_det && matched_r;

  always_comb begin
    kind_new = GCK_NONE;
    if (rx_byte == GC_RESET_PROG) begin
      kind_new = GCK_RESET_PROG;
    end else if (rx_byte == GC_PROG) begin
      kind_new = GCK_PROG;
    end else if (ctrl_r[CTRL_HGC_EN] && rx_byte == alt_r) begin
      kind_new = GCK_HW;
    end
  end
  assign kind_ev = byte_valid && (state_r == ST_GC) && (kind_new != GCK_NONE);

  always_ff @(posedge aclk) begin
    if (!aresetn || !slv_en) begin
      state_r   <= ST_IDLE;
      ack_req_r <= 1'b0;
    end else if (start_det) begin
      state_r   <= ST_ADDR;
      ack_req_r <= 1'b0;
    end else if (stop_det) begin
      state_r   <= ST_IDLE;
      ack_req_r <= 1'b0;
    end else if (byte_valid) begin
      unique case (state_r)
        ST_ADDR: begin
          state_r   <= gc_hit ? ST_GC : (id_hit ? ST_DATA : ST_SKIP);
          ack_req_r <= id_hit || gc_hit;
        end
        ST_GC, ST_DATA: begin
          state_r   <= ST_DATA;
          ack_req_r <= 1'b1;
        end
        ST_IDLE, ST_SKIP: begin
          ack_req_r <= 1'b0;
        end
        default: begin
          state_r   <= ST_IDLE;
          ack_req_r <= 1'b0;
        end
      endcase
    end
  end

  // per-transfer tracking is slave state and is cleared while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !slv_en) begin
      matched_r  <= 1'b0;
      rep_pend_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      if (start_det) begin
        rep_pend_r <= start_flag_r;
        busy_r     <= 1'b1;
      end else if (stop_det) begin
        rep_pend_r <= 1'b0;
        busy_r     <= 1'b0;
      end else if (addr_ev && !(id_hit || gc_hit)) begin
        busy_r <= 1'b0;
      end
      if (addr_ev && (id_hit || gc_hit)) begin
        matched_r <= 1'b1;
      end else if (stop_det) begin
        matched_r <= 1'b0;
      end
    end
  end

  // in every flag below a hardware set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_flag_r <= 1'b0;
      rep_flag_r   <= 1'b0;
      stop_flag_r  <= 1'b0;
      matched_id_index_r      <= 2'h0;
    end else begin
      if (start_set) begin
        start_flag_r <= 1'b1;
      end else if (start_det || stop_det) begin
        start_flag_r <= 1'b0;
      end
      if (rep_set) begin
        rep_flag_r <= 1'b1;
      end else if (rd_status || stop_det) begin
        rep_flag_r <= 1'b0;
      end
      if (stop_set) begin
        stop_flag_r <= 1'b1;
      end else if (rd_status) begin
        stop_flag_r <= 1'b0;
      end
      if (addr_ev && id_hit) begin
        matched_id_index_r <= id_idx;
      end
    end
  end

  // a general call reset does not touch these; only the clear control does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gc_int_r  <= 1'b0;
      gc_kind_r <= GCK_NONE;
    end else begin
      if (addr_ev && gc_hit) begin
        gc_int_r <= 1'b1;
      end else if (gcs_clr) begin
        gc_int_r <= 1'b0;
      end
      if (kind_ev) begin
        gc_kind_r <= kind_new;
      end else if (gcs_clr) begin
        gc_kind_r <= GCK_NONE;
      end
    end
  end

  assign irq_ev = {addr_ev && gc_hit, rep_set, stop_set && ctrl_r[CTRL_STOP_IE]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= IRQ_RST;
      irq        <= 1'b0;
    end else begin
      if (wr_fire && wr_addr_r == OFS_IRQ_STAT && wr_strb_r[0]) begin
        irq_stat_r <= (irq_stat_r & ~wr_data_r[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      // registered output costs one cycle of latency after the status bit
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  start_set_a: assert property (start_set |=> start_flag_r)
    else $error("start flag not set after matching address");
  start_clr_a: assert property ((start_det || stop_det) && !start_set |=> !start_flag_r)
    else $error("start flag survived start or stop");
  rep_set_a: assert property (rep_set |=> rep_flag_r && start_flag_r)
    else $error("repeated start flag not set");
  rep_clr_a: assert property ((rd_status || stop_det) && !rep_set |=> !rep_flag_r)
    else $error("repeated start flag not cleared");
  id_index_a: assert property (addr_ev && id_hit |=> matched_id_index_r == $past(id_idx))
    else $error("matched id index wrong");
  stop_set_a: assert property (stop_det && matched_r |=> stop_flag_r)
    else $error("stop flag not set after matched start");
  stop_clr_a: assert property (rd_status && !stop_set |=> !stop_flag_r)
    else $error("stop flag not cleared by status read");
  stop_irq_a: assert property (stop_set && ctrl_r[CTRL_STOP_IE] && irq_mask_r[IRQ_STOP]
                               && !wr_fire |-> ##2 irq)
    else $error("stop interrupt missing");
  gc_code_a: assert property (kind_ev && rx_byte == GC_RESET_PROG
                              |=> gc_kind_r == GCK_RESET_PROG)
    else $error("general call kind wrong");
  gc_hold_a: assert property (!gcs_clr && !kind_ev |=> $stable(gc_kind_r))
    else $error("general call kind changed without clear");
  gc_clear_a: assert property (gcs_clr && !(addr_ev && gc_hit) |=> !gc_int_r)
    else $error("general call status not cleared");
  slv_hold_a: assert property (!slv_en |=> state_r == ST_IDLE && !sda_oe)
    else $error("slave not held while disabled");
  gc_ack_a: assert property (addr_ev && rx_byte == GC_ADDR && !gc_en |=> !ack_req_r)
    else $error("general call acked while disabled");

  match_stop_c: cover property (addr_ev && id_hit ##[1:1000] stop_set);
  rep_start_c: cover property (rep_set);
  gc_hw_c: cover property (kind_ev && kind_new == GCK_HW);
endmodule

// ==== test/ist_i2c_master.sv ====
// i2c master model: start, repeated start, stop and byte writes
// assumes the bench resolves sda from sda_low and the slave's pull-down
`timescale 1ns/10ps
module ist_i2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // quarter of the 125 ns link period; scl stands high between frames
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // works from idle and, after an ack slot, as a repeated start
  task automatic start_cond();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
    end
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q ack = (sda === 1'b0);
    #Q scl = 1'b0;
    // the slave lets go of sda a few aclk after this fall
    #(2*Q);
  endtask
endmodule

// ==== test/ist_top_bench.sv ====
// self-checking bench: axi4-lite master tasks and an i2c master model
// assumes registered outputs, so a read just after an edge sees its state
`timescale 1ns/10ps
module ist_top_bench;
  import ist_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sda_o, sda_oe, irq, scl, sda_low, sda, a;
  logic [7:0]  awaddr, araddr, alt, gb;
  logic [31:0] wdata, rdata, d;
  logic [31:0] seed = 32'h8C48;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [6:0]  id [4];
  int          err_total, n_tests;
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  ist_top ist_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .irq);
  ist_i2c_master ist_i2c_master_i (.scl, .sda_low, .sda);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] st(input logic s, r, input logic [1:0] i);
    return {s, r, i, 3'b000};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dt = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic adr(input logic [7:0] b, input logic e);
    ist_i2c_master_i.start_cond();
    ist_i2c_master_i.send_byte(b, a);
    chk(a, e);
  endtask
  task automatic stp();
    ist_i2c_master_i.stop_cond();
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, d);
    chk(d, 32'h0);
    chk(resp, RESP_OKAY);
    rd(8'h40, d);
    chk(resp, RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      id[k] = {1'b1, 2'(k), d[3:0]};
      wr(OFS_ID0 + 8'(4 * k), {25'h0, id[k]});
    end
    wr(OFS_CTRL, 32'h105);
    chk(resp, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_IRQ_MASK, {29'h0, {3{k[0]}}});
      adr({id[k], 1'b0}, 1'b1);
      rd(OFS_STATUS, d);
      chk(d[14:8], st(1, 0, 2'(k)));
      d = rnd();
      ist_i2c_master_i.send_byte(d[7:0], a);
      adr({id[k], 1'b0}, 1'b1);
      rd(OFS_STATUS, d);
      chk(d[14:8], st(1, 1, 2'(k)));
      rd(OFS_STATUS, d);
      chk(d[13], 1'b0);
      stp();
      rd(OFS_STATUS, d);
      chk({d[14:13], d[10]}, 3'b001);
      chk(irq, k[0]);
      rd(OFS_STATUS, d);
      chk(d[10], 1'b0);
      rd(OFS_IRQ_STAT, d);
      chk(d, 32'h3);
      wr(OFS_IRQ_STAT, 32'h7);
    end
    d = rnd();
    for (int j = 0; j < 3; j++) begin
      gb = j == 0 ? 8'h7E : j == 1 ? START_BYTE : {HS_PREFIX, 3'(rnd())};
      adr(gb, 1'b0);
      rd(OFS_STATUS, d);
      chk(d[14], j != 0);
      stp();
      rd(OFS_STATUS, d);
      chk(d[10], 1'b0);
    end
    d = rnd();
    alt = d[7:0] | 8'h01;
    wr(OFS_ALT, {24'h0, alt});
    wr(OFS_CTRL, 32'h10D);
    for (int j = 0; j < 4; j++) begin
      adr(GC_ADDR, 1'b1);
      gb = j == 0 ? GC_RESET_PROG : j == 1 ? GC_PROG : j == 2 ? alt : 8'h5A;
      ist_i2c_master_i.send_byte(gb, a);
      stp();
      rd(OFS_STATUS, d);
      chk(d[9:7], {2'(j == 3 ? 3 : j + 1), 1'b1});
    end
    rd(OFS_IRQ_STAT, d);
    chk(d, 32'h5);
    wr(OFS_CTRL, 32'h11D);
    rd(OFS_STATUS, d);
    chk(d[9:7], 3'b000);
    wr(OFS_CTRL, 32'h101);
    adr(GC_ADDR, 1'b0);
    stp();
    wr(OFS_CTRL, 32'h0);
    adr({id[0], 1'b0}, 1'b0);
    rd(OFS_STATUS, d);
    chk(d[14], 1'b0);
    stp();
    stop_test();
  end
  // the sequence needs well under 200 us of link traffic
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
endmodule
